// ==== logic/sgmii_mgmt_pkg.sv ====
`default_nettype none
package sgmii_mgmt_pkg;
    // register addresses on the management bus
    localparam logic [4:0] ADDR_CONTROL   = 5'h00;
    localparam logic [4:0] ADDR_STATUS    = 5'h01;
    localparam logic [4:0] ADDR_PHY_ID_HI = 5'h02;
    localparam logic [4:0] ADDR_PHY_ID_LO = 5'h03;
    localparam logic [4:0] ADDR_ADVERT    = 5'h04;
    localparam logic [4:0] ADDR_EXT_STAT  = 5'h0F;
    localparam logic [4:0] ADDR_IRQ_CTRL  = 5'h10;
    // control register field positions
    localparam int CTL_SOFT_RESET = 15;
    localparam int CTL_LOOPBACK   = 14;
    localparam int CTL_SPEED_LSB  = 13;
    localparam int CTL_AN_ENABLE  = 12;
    localparam int CTL_DUPLEX     = 8;
    localparam int CTL_SPEED_MSB  = 6;
    // interrupt control field positions
    localparam int IRQ_STATUS_BIT = 1;
    localparam int IRQ_ENABLE_BIT = 0;
    // fixed register images
    localparam logic [15:0] EXT_STATUS_VALUE = 16'h8000;
    localparam logic [15:0] ZERO_WORD        = 16'h0000;
    // reset values of the stored bits
    localparam logic RST_LOOPBACK  = 1'b0;
    localparam logic RST_SPEED_LSB = 1'b0;
    localparam logic RST_SPEED_MSB = 1'b1;
    localparam logic RST_AN_ENABLE = 1'b1;
    localparam logic RST_IRQ_EN    = 1'b1;
    localparam logic RST_IRQ_STAT  = 1'b0;
    // speed code reported when controller mode is off or at 2.5G
    localparam logic [1:0] SPEED_1000 = 2'h2;
    // frame layout: op codes and bit counts
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [3:0] HDR_BITS  = 4'hC;
    localparam logic [4:0] DATA_LAST = 5'h11;
    localparam logic [4:0] WR_FIRST  = 5'h02;

    // frame header after the start bits
    typedef struct packed {
        logic [1:0] op;
        logic [4:0] phy;
        logic [4:0] regad;
    } mdio_hdr_t;

    // stored control bits
    typedef struct packed {
        logic soft_reset;
        logic loopback;
        logic speed_lsb;
        logic an_enable;
        logic speed_msb;
    } ctrl_t;

    // serial frame states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_HDR   = 2'b10,
        ST_DATA  = 2'b11
    } mdio_state_t;
endpackage
`default_nettype wire

// ==== logic/sgmii_mgmt_register_bank.sv ====
`default_nettype none
module sgmii_mgmt_register_bank (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    // management serial pins, sampled as synchronous inputs
    input  wire logic        MDC,
    input  wire logic        MDIO_IN,
    output logic             MDIO_OUT,
    output logic             MDIO_OE,
    input  wire logic [4:0]  PHY_ADDR,
    // optional configuration vector for the control register
    input  wire logic        CFG_VALID,
    input  wire logic [15:0] CFG_DATA,
    // core status and mode straps
    input  wire logic        CLOCK_LOCK_INDICATION,
    input  wire logic        AN_COMPLETE,
    input  wire logic        CONTROLLER_MODE,
    input  wire logic        TBI_VARIANT,
    input  wire logic        RATE_2G5,
    // control outputs to the core
    output logic             NEGOTIATION_DONE_IRQ_PIN,
    output logic             LOOPBACK_INTERNAL,
    output logic             WRAP_OUT,
    output logic             AN_ENABLE_OUT,
    output logic [1:0]       SPEED_SEL_OUT,
    output logic             CORE_RESET_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [1:0]                 rst_pipe_reg;  // reset release stages
    logic                       rst_n;         // synchronised reset
    logic                       mdc_q_reg;     // last clock level
    logic                       mdc_rise;      // bit sample strobe
    sgmii_mgmt_pkg::mdio_state_t state_reg;    // frame state
    logic [11:0]                hdr_reg;       // header shift
    sgmii_mgmt_pkg::mdio_hdr_t  hdr;           // header view
    logic [3:0]                 hdr_cnt_reg;   // header bits seen
    logic [4:0]                 dat_cnt_reg;   // bits after header
    logic                       is_read_reg;   // frame reads us
    logic                       is_write_reg;  // frame writes us
    logic [4:0]                 regad_reg;     // addressed register
    logic [15:0]                rd_shift_reg;  // outgoing data
    logic [15:0]                wr_shift_reg;  // incoming data
    logic                       wr_commit;     // write lands now
    logic [15:0]                wr_word;       // completed word
    sgmii_mgmt_pkg::ctrl_t      ctrl_reg;      // control bits
    logic                       irq_en_reg;    // interrupt enable
    logic                       irq_stat_reg;  // interrupt status
    logic                       restore;       // return to defaults
    logic                       ctl_load;      // control write
    logic [15:0]                ctl_word;      // control write data
    logic                       irq_clear;     // status zero written

    // register image as seen by a read
    function automatic logic [15:0] reg_image(
        input logic [4:0]            addr,
        input sgmii_mgmt_pkg::ctrl_t c,
        input logic                  gem,
        input logic                  ien,
        input logic                  ist
    );
        logic [15:0] v;
        v = sgmii_mgmt_pkg::ZERO_WORD;
        unique case (addr)
            sgmii_mgmt_pkg::ADDR_CONTROL: begin
                v[sgmii_mgmt_pkg::CTL_SOFT_RESET] = c.soft_reset;
                v[sgmii_mgmt_pkg::CTL_LOOPBACK]   = c.loopback;
                v[sgmii_mgmt_pkg::CTL_SPEED_LSB]  = gem & c.speed_lsb;
                v[sgmii_mgmt_pkg::CTL_AN_ENABLE]  = c.an_enable;
                v[sgmii_mgmt_pkg::CTL_DUPLEX]     = 1'b1;
                v[sgmii_mgmt_pkg::CTL_SPEED_MSB]  = ~gem | c.speed_msb;
            end
            // fixed duplex abilities, reserved low bits stay zero
            sgmii_mgmt_pkg::ADDR_EXT_STAT:
                v = sgmii_mgmt_pkg::EXT_STATUS_VALUE;
            sgmii_mgmt_pkg::ADDR_IRQ_CTRL: begin
                v[sgmii_mgmt_pkg::IRQ_STATUS_BIT] = ist;
                v[sgmii_mgmt_pkg::IRQ_ENABLE_BIT] = ien;
            end
            // status, identifier, advertisement contents live elsewhere
            default: v = sgmii_mgmt_pkg::ZERO_WORD;
        endcase
        return v;
    endfunction

    // write decode, shared by every register that takes writes
    function automatic logic hits(input logic [4:0] a, input logic [4:0] t);
        return a == t;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release through two stages
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_reg[1];
    // lock loss and soft reset reload defaults on the clock
    assign restore = ~CLOCK_LOCK_INDICATION | ctrl_reg.soft_reset;

    ////////////////////////////////////////////////////////////////////////
    // serial clock edge detect; pins are already synchronous
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            mdc_q_reg <= 1'b0;
        end else begin
            mdc_q_reg <= MDC;
        end
    end
    assign mdc_rise = MDC & ~mdc_q_reg;
    assign hdr      = {hdr_reg[10:0], MDIO_IN}; // header with its last bit
    // frame sequencer: start, 12 header bits, turnaround and 16 data
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= sgmii_mgmt_pkg::ST_IDLE;
            hdr_reg      <= 12'h000;
            hdr_cnt_reg  <= 4'h0;
            dat_cnt_reg  <= 5'h00;
            is_read_reg  <= 1'b0;
            is_write_reg <= 1'b0;
            regad_reg    <= 5'h00;
        end else if (mdc_rise) begin
            unique case (state_reg)
                // preamble ones are optional; a zero opens the start
                sgmii_mgmt_pkg::ST_IDLE: begin
                    if (!MDIO_IN) begin
                        state_reg <= sgmii_mgmt_pkg::ST_START;
                    end
                end
                sgmii_mgmt_pkg::ST_START: begin
                    hdr_cnt_reg <= 4'h0;
                    state_reg   <= MDIO_IN ? sgmii_mgmt_pkg::ST_HDR
                                           : sgmii_mgmt_pkg::ST_START;
                end
                sgmii_mgmt_pkg::ST_HDR: begin
                    hdr_reg     <= {hdr_reg[10:0], MDIO_IN};
                    hdr_cnt_reg <= hdr_cnt_reg + 4'h1;
                    if (hdr_cnt_reg == sgmii_mgmt_pkg::HDR_BITS - 4'h1) begin
                        // frames for other addresses are still walked
                        // to the end so their data is not a false start
                        is_read_reg  <= hdr.op == sgmii_mgmt_pkg::OP_READ &&
                                        hdr.phy == PHY_ADDR;
                        is_write_reg <= hdr.op == sgmii_mgmt_pkg::OP_WRITE &&
                                        hdr.phy == PHY_ADDR;
                        regad_reg    <= hdr.regad;
                        dat_cnt_reg  <= 5'h00;
                        state_reg    <= sgmii_mgmt_pkg::ST_DATA;
                    end
                end
                sgmii_mgmt_pkg::ST_DATA: begin
                    dat_cnt_reg <= dat_cnt_reg + 5'h01;
                    if (dat_cnt_reg == sgmii_mgmt_pkg::DATA_LAST) begin
                        is_read_reg  <= 1'b0;
                        is_write_reg <= 1'b0;
                        state_reg    <= sgmii_mgmt_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // read data is frozen when the header completes
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rd_shift_reg <= 16'h0000;
        end else if (mdc_rise) begin
            if (state_reg == sgmii_mgmt_pkg::ST_HDR &&
                hdr_cnt_reg == sgmii_mgmt_pkg::HDR_BITS - 4'h1) begin
                rd_shift_reg <= reg_image({hdr_reg[3:0], MDIO_IN},
                                          ctrl_reg, CONTROLLER_MODE,
                                          irq_en_reg, irq_stat_reg);
            end else if (state_reg == sgmii_mgmt_pkg::ST_DATA &&
                         dat_cnt_reg != 5'h00) begin
                rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
            end
        end
    end

    // pin driver: zero for the second turnaround bit, then data
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            MDIO_OE  <= 1'b0;
            MDIO_OUT <= 1'b0;
        end else if (mdc_rise) begin
            if (state_reg == sgmii_mgmt_pkg::ST_DATA && is_read_reg &&
                dat_cnt_reg != sgmii_mgmt_pkg::DATA_LAST) begin
                MDIO_OE  <= 1'b1;
                MDIO_OUT <= (dat_cnt_reg == 5'h00) ? 1'b0
                                                   : rd_shift_reg[15];
            end else begin
                MDIO_OE  <= 1'b0;
                MDIO_OUT <= 1'b0;
            end
        end
    end

    // write data capture after both turnaround bits
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_shift_reg <= 16'h0000;
        end else if (mdc_rise && state_reg == sgmii_mgmt_pkg::ST_DATA &&
                     dat_cnt_reg >= sgmii_mgmt_pkg::WR_FIRST) begin
            wr_shift_reg <= {wr_shift_reg[14:0], MDIO_IN};
        end
    end
    assign wr_word   = {wr_shift_reg[14:0], MDIO_IN};
    assign wr_commit = mdc_rise && is_write_reg &&
                       state_reg == sgmii_mgmt_pkg::ST_DATA &&
                       dat_cnt_reg == sgmii_mgmt_pkg::DATA_LAST;

    ////////////////////////////////////////////////////////////////////////
    // control register: serial write wins over the configuration vector
    assign ctl_load = (wr_commit &&
                       hits(regad_reg, sgmii_mgmt_pkg::ADDR_CONTROL))
                      || CFG_VALID;
    assign ctl_word = (wr_commit &&
                       hits(regad_reg, sgmii_mgmt_pkg::ADDR_CONTROL))
                      ? wr_word : CFG_DATA;

    // stored control bits; writes to other addresses fall away
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg.soft_reset <= 1'b0;
            ctrl_reg.loopback   <= sgmii_mgmt_pkg::RST_LOOPBACK;
            ctrl_reg.speed_lsb  <= sgmii_mgmt_pkg::RST_SPEED_LSB;
            ctrl_reg.an_enable  <= sgmii_mgmt_pkg::RST_AN_ENABLE;
            ctrl_reg.speed_msb  <= sgmii_mgmt_pkg::RST_SPEED_MSB;
        end else if (restore) begin
            // this also drops the soft reset bit one cycle after it set
            ctrl_reg.soft_reset <= 1'b0;
            ctrl_reg.loopback   <= sgmii_mgmt_pkg::RST_LOOPBACK;
            ctrl_reg.speed_lsb  <= sgmii_mgmt_pkg::RST_SPEED_LSB;
            ctrl_reg.an_enable  <= sgmii_mgmt_pkg::RST_AN_ENABLE;
            ctrl_reg.speed_msb  <= sgmii_mgmt_pkg::RST_SPEED_MSB;
        end else if (ctl_load) begin
            ctrl_reg.soft_reset <= ctl_word[sgmii_mgmt_pkg::CTL_SOFT_RESET];
            ctrl_reg.loopback   <= ctl_word[sgmii_mgmt_pkg::CTL_LOOPBACK];
            ctrl_reg.an_enable  <= ctl_word[sgmii_mgmt_pkg::CTL_AN_ENABLE];
            // speed bits only take writes in controller mode
            if (CONTROLLER_MODE) begin
                ctrl_reg.speed_lsb <=
                    ctl_word[sgmii_mgmt_pkg::CTL_SPEED_LSB];
                ctrl_reg.speed_msb <=
                    ctl_word[sgmii_mgmt_pkg::CTL_SPEED_MSB];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt control; hardware set beats a clearing write
    assign irq_clear = wr_commit &&
                       hits(regad_reg, sgmii_mgmt_pkg::ADDR_IRQ_CTRL) &&
                       !wr_word[sgmii_mgmt_pkg::IRQ_STATUS_BIT];

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_reg <= sgmii_mgmt_pkg::RST_IRQ_EN;
        end else if (restore) begin
            irq_en_reg <= sgmii_mgmt_pkg::RST_IRQ_EN;
        end else if (wr_commit &&
                     hits(regad_reg, sgmii_mgmt_pkg::ADDR_IRQ_CTRL)) begin
            irq_en_reg <= wr_word[sgmii_mgmt_pkg::IRQ_ENABLE_BIT];
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= sgmii_mgmt_pkg::RST_IRQ_STAT;
        end else if (restore || !irq_en_reg) begin
            irq_stat_reg <= 1'b0;
        end else if (AN_COMPLETE) begin
            irq_stat_reg <= 1'b1;
        end else if (irq_clear) begin
            irq_stat_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs to the core
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            NEGOTIATION_DONE_IRQ_PIN <= 1'b0;
            LOOPBACK_INTERNAL        <= 1'b0;
            WRAP_OUT                 <= 1'b0;
            AN_ENABLE_OUT            <= sgmii_mgmt_pkg::RST_AN_ENABLE;
            SPEED_SEL_OUT            <= sgmii_mgmt_pkg::SPEED_1000;
            CORE_RESET_OUT           <= 1'b1;
        end else begin
            NEGOTIATION_DONE_IRQ_PIN <= irq_stat_reg;
            LOOPBACK_INTERNAL <= ctrl_reg.loopback & ~TBI_VARIANT;
            WRAP_OUT          <= ctrl_reg.loopback & TBI_VARIANT;
            AN_ENABLE_OUT     <= ctrl_reg.an_enable;
            // one speed only at 2.5G, so the bits are not looked at
            SPEED_SEL_OUT <= (CONTROLLER_MODE && !RATE_2G5)
                             ? {ctrl_reg.speed_msb, ctrl_reg.speed_lsb}
                             : sgmii_mgmt_pkg::SPEED_1000;
            CORE_RESET_OUT <= restore;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n);

    sequence s_hdr_done(logic [4:0] a);
        mdc_rise && state_reg == sgmii_mgmt_pkg::ST_HDR &&
        hdr_cnt_reg == sgmii_mgmt_pkg::HDR_BITS - 4'h1 &&
        {hdr_reg[3:0], MDIO_IN} == a;
    endsequence
    property p_ext_status;
        s_hdr_done(sgmii_mgmt_pkg::ADDR_EXT_STAT) |=>
            rd_shift_reg[15:12] == 4'h8 && rd_shift_reg[11:0] == 12'h000;
    endproperty
    a_ext_status: assert property (p_ext_status)
        else $error("extended status image wrong");
    property p_undefined_zero;
        s_hdr_done(5'h07) |=> rd_shift_reg == 16'h0000;
    endproperty
    a_undefined_zero: assert property (p_undefined_zero)
        else $error("undefined address did not read zero");
    property p_irq_set;
        irq_en_reg && AN_COMPLETE && !restore |=> irq_stat_reg ##1
            NEGOTIATION_DONE_IRQ_PIN;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("completion did not raise interrupt");
    property p_irq_sticky;
        irq_stat_reg && irq_en_reg && !restore && !irq_clear |=>
            irq_stat_reg;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky)
        else $error("interrupt status dropped without clear");
    property p_irq_disabled;
        !irq_en_reg |=> !irq_stat_reg;
    endproperty
    a_irq_disabled: assert property (p_irq_disabled)
        else $error("status set while disabled");
    property p_irq_pin;
        NEGOTIATION_DONE_IRQ_PIN == $past(irq_stat_reg);
    endproperty
    a_irq_pin: assert property (p_irq_pin)
        else $error("interrupt pin does not follow status");
    // a lock loss may last many cycles, so only the next cycle is judged
    property p_restore;
        restore |=> irq_en_reg && ctrl_reg.an_enable && !ctrl_reg.loopback &&
            !ctrl_reg.soft_reset && !irq_stat_reg && CORE_RESET_OUT;
    endproperty
    a_restore: assert property (p_restore)
        else $error("defaults not restored");
    property p_soft_clear;
        ctrl_reg.soft_reset |=> !ctrl_reg.soft_reset && CORE_RESET_OUT;
    endproperty
    a_soft_clear: assert property (p_soft_clear)
        else $error("soft reset bit did not clear");
    property p_wrap;
        ctrl_reg.loopback && TBI_VARIANT |=> WRAP_OUT && !LOOPBACK_INTERNAL;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap output not following loopback");

endmodule
`default_nettype wire

// ==== verif/mdio_station.sv ====
`default_nettype none
module mdio_station (
    // clock
    input  wire logic clk,
    // management pins
    output var  logic mdc,
    output var  logic mdio,
    input  wire logic line_out,
    input  wire logic line_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released line floats high on the board pull-up
    wire line = line_oe ? line_out : 1'b1;
    initial begin
        mdc = 1'b0;
        mdio = 1'b1;
    end
    // one whole frame; mdc stands still low between frames
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [31:0] bits;
        rd = 16'h0000;
        bits = {2'b01, op, phy, ra,
                (op == 2'h2) ? 18'h3FFFF : {2'b10, wd}};
        for (int k = 31; k >= 0; k--) begin
            @(negedge clk);
            mdc = 1'b0;
            mdio = bits[k];
            repeat (4) @(negedge clk);
            // answer of the previous rise, settled by now
            if (k < 16) rd = {rd[14:0], line};
            mdc = 1'b1;
            repeat (3) @(negedge clk);
        end
        @(negedge clk);
        mdc = 1'b0;
        mdio = 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== verif/sgmii_mgmt_register_bank_bench.sv ====
`default_nettype none
module sgmii_mgmt_register_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] PHY = 5'h05; // strapped device address
    logic clk, rst_n, mdc, mdio_in, mdio_out, mdio_oe, cfg_valid, lock;
    logic an_done, gem, tbi, r2g5, irq, lb_int, wrap, an_en, core_rst;
    logic saw_rst;
    logic [15:0] cfg_data, rd;
    logic [1:0]  spd;
    int          err_count, n_tests;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // sticky record of a core reset pulse, which lasts one cycle only after a soft reset
    always @(posedge clk) if (core_rst === 1'b1) saw_rst <= 1'b1;
    mdio_station u_sta (.clk(clk), .mdc(mdc), .mdio(mdio_in),
                        .line_out(mdio_out), .line_oe(mdio_oe));
    sgmii_mgmt_register_bank DUT (.SYS_CLK(clk), .RST_N(rst_n), .MDC(mdc),
        .MDIO_IN(mdio_in), .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe),
        .PHY_ADDR(PHY), .CFG_VALID(cfg_valid), .CFG_DATA(cfg_data),
        .CLOCK_LOCK_INDICATION(lock), .AN_COMPLETE(an_done),
        .CONTROLLER_MODE(gem), .TBI_VARIANT(tbi), .RATE_2G5(r2g5),
        .NEGOTIATION_DONE_IRQ_PIN(irq), .LOOPBACK_INTERNAL(lb_int),
        .WRAP_OUT(wrap), .AN_ENABLE_OUT(an_en), .SPEED_SEL_OUT(spd),
        .CORE_RESET_OUT(core_rst));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        u_sta.frame(sgmii_mgmt_pkg::OP_WRITE, PHY, a, d, rd);
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
        u_sta.frame(sgmii_mgmt_pkg::OP_READ, PHY, a, 16'h0000, rd);
        chk(rd, e);
    endtask
    // one negotiation-complete pulse, then let the pin settle
    task automatic an_pulse;
        @(negedge clk) an_done = 1'b1;
        @(negedge clk) an_done = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_map;
        logic [4:0] blank [6] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h07, 5'h1F};
        rdchk(sgmii_mgmt_pkg::ADDR_CONTROL, 16'h1140);
        rdchk(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0001);
        rdchk(sgmii_mgmt_pkg::ADDR_EXT_STAT, 16'h8000);
        chk({14'h0000, spd}, 16'h0002);
        chk({15'h0000, an_en}, 16'h0001);
        foreach (blank[i]) rdchk(blank[i], 16'h0000);
        wr(5'h1F, 16'hFFFF);
        rdchk(5'h1F, 16'h0000);
        wr(sgmii_mgmt_pkg::ADDR_EXT_STAT, 16'hFFFF);
        rdchk(sgmii_mgmt_pkg::ADDR_EXT_STAT, 16'h8000);
        wr(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'hFFFC);
        rdchk(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0000);
        wr(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0001);
        // a frame for another device must leave the bank untouched
        u_sta.frame(sgmii_mgmt_pkg::OP_WRITE, PHY ^ 5'h01, 5'h00,
                    16'h0000, rd);
        rdchk(sgmii_mgmt_pkg::ADDR_CONTROL, 16'h1140);
        $display("test map done");
    endtask
    task automatic t_ctrl;
        wr(sgmii_mgmt_pkg::ADDR_CONTROL, 16'h5000);
        chk({14'h0000, lb_int, wrap}, 16'h0002);
        tbi = 1'b1;
        repeat (2) @(negedge clk);
        chk({14'h0000, lb_int, wrap}, 16'h0001);
        wr(sgmii_mgmt_pkg::ADDR_CONTROL, 16'h2000);
        rdchk(sgmii_mgmt_pkg::ADDR_CONTROL, 16'h0140);
        chk({15'h0000, an_en}, 16'h0000);
        gem = 1'b1;
        wr(sgmii_mgmt_pkg::ADDR_CONTROL, 16'h2000);
        rdchk(sgmii_mgmt_pkg::ADDR_CONTROL, 16'h2100);
        chk({14'h0000, spd}, 16'h0001);
        r2g5 = 1'b1;
        repeat (2) @(negedge clk);
        chk({14'h0000, spd}, 16'h0002);
        {gem, r2g5, tbi} = 3'h0;
        // configuration vector loads the control word directly
        @(negedge clk) {cfg_data, cfg_valid} = {16'h4000, 1'b1};
        @(negedge clk) cfg_valid = 1'b0;
        rdchk(sgmii_mgmt_pkg::ADDR_CONTROL, 16'h4140);
        $display("test control done");
    endtask
    task automatic t_irq;
        an_pulse();
        rdchk(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0003);
        chk({15'h0000, irq}, 16'h0001);
        wr(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0003);
        rdchk(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0003);
        wr(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0001);
        rdchk(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
        an_pulse();
        wr(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0002);
        rdchk(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0000);
        an_pulse();
        rdchk(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        $display("test interrupt done");
    endtask
    task automatic t_resets;
        saw_rst = 1'b0;
        wr(sgmii_mgmt_pkg::ADDR_CONTROL, 16'h8000);
        repeat (4) @(negedge clk);
        chk({15'h0000, saw_rst}, 16'h0001);
        rdchk(sgmii_mgmt_pkg::ADDR_CONTROL, 16'h1140);
        rdchk(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0001);
        // losing clock lock must also restore the defaults
        wr(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0000);
        @(negedge clk) lock = 1'b0;
        repeat (3) @(negedge clk);
        lock = 1'b1;
        repeat (4) @(negedge clk);
        rdchk(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0001);
        wr(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0000);
        @(negedge clk) rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        rdchk(sgmii_mgmt_pkg::ADDR_IRQ_CTRL, 16'h0001);
        $display("test resets done");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, cfg_valid, cfg_data, an_done, gem, tbi, r2g5} = 22'h0;
        {lock, saw_rst, err_count, n_tests} = '0;
        lock = 1'b1;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_map();
        t_ctrl();
        t_irq();
        t_resets();
        summarize();
    end
    // a hung run is cut short and counted as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
